// ---- testbench/cmc_checker_tb_top.sv ----
// Self-checking bench of the configuration CRC checker
`timescale 1ns/100ps

module cmc_checker_tb_top
    import cmc_pkg::*;
;
    localparam int FW    = 2;
    localparam int FR    = 2;
    localparam int DEPTH = FW * FR;
    localparam int LIM   = 3 * DEPTH;

    logic          clk    = 1'b0;
    logic          rst_n  = 1'b0;
    cmc_cfg_word_t cfg    = '0;
    logic          en     = 1'b1;
    logic          od     = 1'b0;
    logic          strike = 1'b0;
    logic [15:0]   s_addr = '0;
    logic [4:0]    s_bit  = '0;
    cmc_tap_t      tap;
    logic          tdo, user, cerr, flag, pin_o, pin_oe, pin;
    int            bad_count       = 0;
    int            samples_checked = 0;
    int            a;
    logic [31:0]   cells [DEPTH];
    logic [31:0]   good, wrong, got;

    initial forever #25 clk = ~clk;

    cmc_checker #(
        .FRAME_WORDS (FW),
        .FRAMES      (FR)
    ) dut (
        .clk               (clk),
        .rst_n             (rst_n),
        .cfg_in            (cfg),
        .check_enable      (en),
        .od_mode           (od),
        .seu_strike        (strike),
        .seu_addr          (s_addr),
        .seu_bit           (s_bit),
        .tap               (tap),
        .tdo               (tdo),
        .user_mode         (user),
        .cfg_error         (cerr),
        .crc_mismatch_flag (flag),
        .crc_pin_o         (pin_o),
        .crc_pin_oe        (pin_oe)
    );

    cmc_far_side far (
        .clk       (clk),
        .tap       (tap),
        .tdo       (tdo),
        .pin_o     (pin_o),
        .pin_oe    (pin_oe),
        .pin_level (pin)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] f_crc16(logic [15:0] c, logic [31:0] w);
        for (int i = 31; i >= 0; i--)
            c = (c << 1) ^ ((c[15] ^ w[i]) ? CMC_CRC16_POLY : '0);
        return c;
    endfunction

    function automatic logic [31:0] f_sig();
        logic [31:0] c;
        c = CMC_CRC32_INIT;
        for (int k = 0; k < DEPTH; k++)
            for (int i = 31; i >= 0; i--)
                c = (c << 1) ^ ((c[31] ^ cells[k][i]) ? CMC_CRC32_POLY : '0);
        return c;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_flag(input logic v);
        // Never sample the flag in the time step of the edge that moves it
        @(negedge clk);
        for (int n = 0; n < LIM && flag !== v; n++)
            @(negedge clk);
        if (flag !== v) begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic pins(input logic e);
        @(negedge clk);
        check(flag, e);
        check(pin, e);
        check(pin_oe, od ? !e : 1'b1);
    endtask

    task automatic put(input cmc_kind_t k, input logic [31:0] d);
        @(posedge clk);
        cfg <= '{1'b1, k, d};
    endtask

    // Frame bad_fr gets a broken frame CRC; -1 loads cleanly
    task automatic configure(input int bad_fr);
        logic [15:0] c;
        for (int f = 0; f < FR; f++) begin
            c = CMC_CRC16_INIT;
            for (int w = 0; w < FW; w++) begin
                cells[f*FW+w] = $urandom;
                c = f_crc16(c, cells[f*FW+w]);
                put(CMC_K_DATA, cells[f*FW+w]);
            end
            put(CMC_K_FCRC, {16'h0000, c ^ 16'(f == bad_fr)});
        end
        good = f_sig();
        put(CMC_K_REF, good);
        put(CMC_K_IDLE, $urandom);
        @(posedge clk);
        cfg.valid <= 1'b0;
    endtask

    task automatic hit(input int adr, input int b);
        @(posedge clk);
        strike <= 1'b1;
        s_addr <= 16'(adr);
        s_bit <= 5'(b);
        cells[adr][b] = ~cells[adr][b];
        @(posedge clk);
        strike <= 1'b0;
    endtask

    initial begin
        void'($urandom(96));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        configure(1);
        repeat (3) @(negedge clk);
        check(cerr, 1'b1);
        check(user, 1'b0);
        $display("test bad_frame done");

        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Access before user mode must change nothing
        far.scan(CMC_IR_REF_LOAD, $urandom, got);
        configure(-1);
        @(negedge clk);
        check(user, 1'b1);
        check(cerr, 1'b0);
        repeat (LIM) @(negedge clk);
        pins(1'b0);
        far.scan(CMC_IR_REF_LOAD, good, got);
        check(got, good);
        $display("test clean_load done");

        // Strike while paused: no verdict until scanning resumes
        @(posedge clk);
        en <= 1'b0;
        // Last cell left out: its restore must land after it is read in this pass
        a = $urandom_range(DEPTH - 2);
        hit(a, $urandom_range(31));
        repeat (LIM) @(negedge clk);
        check(flag, 1'b0);
        @(posedge clk);
        en <= 1'b1;
        wait_flag(1'b1);
        pins(1'b1);
        hit(a, s_bit);
        repeat (DEPTH - 2) begin
            @(negedge clk);
            check(flag, 1'b1);
        end
        wait_flag(1'b0);
        pins(1'b0);
        $display("test upset done");

        @(posedge clk);
        od <= 1'b1;
        wrong = good ^ (32'h0000_0001 << $urandom_range(31));
        far.scan(CMC_IR_REF_LOAD ^ 10'h001, wrong, got);
        repeat (LIM) @(negedge clk);
        check(flag, 1'b0);
        far.scan(CMC_IR_REF_LOAD, wrong, got);
        check(got, good);
        wait_flag(1'b1);
        pins(1'b1);
        far.scan(CMC_IR_REF_LOAD, good, got);
        check(got, wrong);
        wait_flag(1'b0);
        pins(1'b0);
        $display("test inject done");

        hit($urandom_range(DEPTH - 1), $urandom_range(31));
        wait_flag(1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check(flag, 1'b0);
        check(user, 1'b0);
        check(pin, 1'b0);
        $display("test reconfig done");
        summarize();
    end
endmodule

// ---- testbench/cmc_far_side.sv ----
// Far-side model: test-port driver of the reference scan and pin monitor
`timescale 1ns/100ps

module cmc_far_side
    import cmc_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Test access
    output cmc_tap_t  tap,
    input  wire logic tdo,
    // Error pin
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_level
);
    // External pull-up holds a released pin high
    assign pin_level = pin_oe ? pin_o : 1'b1;

    initial tap = '0;

    ////////////////////////////////////////////////////////////////////////
    // Capture, 32 shifts LSB first, update; tdo read mid-cycle
    task automatic scan(input logic [CMC_IR_W-1:0] ir,
                        input logic [31:0] din,
                        output logic [31:0] dout);
        @(posedge clk);
        tap.ir <= ir;
        tap.capture <= 1'b1;
        @(posedge clk);
        tap.capture <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            tap.shift <= 1'b1;
            tap.tdi <= din[i];
            @(negedge clk);
            dout[i] = tdo;
            @(posedge clk);
        end
        tap.shift <= 1'b0;
        tap.update <= 1'b1;
        @(posedge clk);
        tap.update <= 1'b0;
        tap.ir <= '0;
        // Idle data line flips after every scan so a stale bit is never trusted
        tap.tdi <= ~tap.tdi;
    endtask
endmodule

// ---- verilog/cmc_checker.sv ----
// Configuration cell array with frame CRC load check and user-mode scrubber
//
// Functional notes
// - Each loaded frame gets a CRC, compared with the frame CRC in stream.
// - Loading continues frame by frame until a mismatch or all frames done.
// - At end of loading the delivered whole-array CRC goes to reference.
// - In user mode the array CRC is recomputed and compared to reference.
// - Checking stops only on reset by the reconfiguration input or while check_enable is low.
// - Only configuration cells are covered, no memory blocks or I/O state.
// - One 32-bit CRC with the IEEE 802 polynomial covers the whole array.
// - Unchanged cells give an all-zero signature and a low mismatch flag.
// - An upset cell gives a non-zero signature and a high mismatch flag.
// - Instruction 00 0001 0101 puts the reference between TDI and TDO.
// - The reference access instruction only acts in user mode.
// - Rewriting reference needs no reload; checking uses the new value.
// - A wrong reference value makes the mismatch flag rise.
// - Restoring the right reference value makes the mismatch flag fall.
// - Error pin is push-pull by default, open-drain when so configured.
// - A raised flag holds through the next pass; cleared only if clean.
// - With checking enabled, scanning starts on entry to user mode.
// - Reference access does not halt the user logic.
`timescale 1ns/100ps

module cmc_checker
    import cmc_pkg::*;
#(
    parameter int unsigned FRAME_WORDS = 4,
    parameter int unsigned FRAMES      = 8
) (
    // Clock and reset (reset is the reconfiguration request)
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Configuration stream
    input  wire cmc_cfg_word_t cfg_in,
    // Options
    input  wire logic          check_enable,
    input  wire logic          od_mode,
    // Upset model: flips one cell bit
    input  wire logic          seu_strike,
    input  wire logic [15:0]   seu_addr,
    input  wire logic [4:0]    seu_bit,
    // Test access port, already decoded
    input  wire cmc_tap_t      tap,
    output logic               tdo,
    // Status
    output logic               user_mode,
    output logic               cfg_error,
    output logic               crc_mismatch_flag,
    output logic               crc_pin_o,
    output logic               crc_pin_oe
);

    localparam int unsigned DEPTH = FRAME_WORDS * FRAMES;
    localparam int unsigned AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned WW    = $clog2(FRAME_WORDS + 1);
    localparam int unsigned FW    = $clog2(FRAMES + 1);
    localparam logic [AW-1:0] LAST_ADDR  = AW'(DEPTH - 1);
    localparam logic [WW-1:0] LAST_WORD  = WW'(FRAME_WORDS - 1);
    localparam logic [FW-1:0] LAST_FRAME = FW'(FRAMES - 1);

    ////////////////////////////////////////////////////////////////////////
    // State
    cmc_state_t    state_q, state_d;
    logic [AW-1:0] wr_ptr_q, wr_ptr_d;
    logic [WW-1:0] word_cnt_q, word_cnt_d;
    logic [FW-1:0] frame_cnt_q, frame_cnt_d;
    logic          expect_fcrc_q, expect_fcrc_d;
    logic          frames_done_q, frames_done_d;
    logic [15:0]   fcrc_q, fcrc_d;
    logic [31:0]   ref_q, ref_d;
    logic [31:0]   crc_q, crc_d;
    logic [AW-1:0] rd_ptr_q, rd_ptr_d;
    logic [31:0]   sig_q, sig_d;
    logic          flag_q, flag_d;
    logic [31:0]   sr_q, sr_d;
    logic          tdo_q, tdo_d;
    logic          pin_o_q, pin_o_d;
    logic          pin_oe_q, pin_oe_d;
    logic          user_q, user_d;
    logic          cerr_q, cerr_d;

    logic          mem_we;
    logic          pass_end;
    logic          fcrc_bad;
    logic          ref_take;
    logic          tap_sel;
    logic [31:0]   crc_next;

    // Only configuration cells live here; memory blocks are elsewhere
    logic [31:0]   cells [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // Cell array write: loading, or a modelled upset in user mode
    always_ff @(posedge clk) begin
        if (mem_we) begin
            cells[wr_ptr_q] <= cfg_in.data;
        end else if (seu_strike && state_q == CMC_S_USER
                     && seu_addr < 16'(DEPTH)) begin
            cells[seu_addr[AW-1:0]][seu_bit] <=
                ~cells[seu_addr[AW-1:0]][seu_bit];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_d       = state_q;
        wr_ptr_d      = wr_ptr_q;
        word_cnt_d    = word_cnt_q;
        frame_cnt_d   = frame_cnt_q;
        expect_fcrc_d = expect_fcrc_q;
        frames_done_d = frames_done_q;
        fcrc_d        = fcrc_q;
        ref_d         = ref_q;
        crc_d         = crc_q;
        rd_ptr_d      = rd_ptr_q;
        sig_d         = sig_q;
        flag_d        = flag_q;
        sr_d          = sr_q;
        mem_we        = 1'b0;
        pass_end      = 1'b0;
        fcrc_bad      = 1'b0;
        ref_take      = 1'b0;
        crc_next      = cmc_crc32(crc_q, cells[rd_ptr_q]);

        // Loading: data words, then the frame CRC word
        if (state_q == CMC_S_CONFIG && cfg_in.valid) begin
            case (cfg_in.kind)
                CMC_K_DATA: begin
                    if (!expect_fcrc_q && !frames_done_q) begin
                        mem_we     = 1'b1;
                        fcrc_d     = cmc_crc16(fcrc_q, cfg_in.data);
                        wr_ptr_d   = wr_ptr_q + 1'b1;
                        word_cnt_d = word_cnt_q + 1'b1;
                        if (word_cnt_q == LAST_WORD) begin
                            expect_fcrc_d = 1'b1;
                        end
                    end
                end
                CMC_K_FCRC: begin
                    if (expect_fcrc_q) begin
                        if (cfg_in.data[15:0] != fcrc_q) begin
                            fcrc_bad = 1'b1;
                            state_d  = CMC_S_CFG_ERR;
                        end else begin
                            fcrc_d        = CMC_CRC16_INIT;
                            word_cnt_d    = '0;
                            expect_fcrc_d = 1'b0;
                            frame_cnt_d   = frame_cnt_q + 1'b1;
                            if (frame_cnt_q == LAST_FRAME) begin
                                frames_done_d = 1'b1;
                            end
                        end
                    end
                end
                CMC_K_REF: begin
                    if (frames_done_q) begin
                        ref_take = 1'b1;
                        ref_d    = cfg_in.data;
                        state_d  = CMC_S_USER;
                    end
                end
                default: begin
                end
            endcase
        end

        // Scrubbing runs every cycle in user mode while check_enable is high
        if (state_q == CMC_S_USER && check_enable) begin
            crc_d    = crc_next;
            rd_ptr_d = rd_ptr_q + 1'b1;
            if (rd_ptr_q == LAST_ADDR) begin
                pass_end = 1'b1;
                rd_ptr_d = '0;
                crc_d    = CMC_CRC32_INIT;
                sig_d    = crc_next ^ ref_q;
                // Flag only moves at a pass end, so it holds a full pass
                flag_d   = (sig_d != 32'h0000_0000);
            end
        end

        // Reference access works beside the scrubber, no stall
        tap_sel = state_q == CMC_S_USER && tap.ir == CMC_IR_REF_LOAD;
        if (tap_sel) begin
            if (tap.capture) begin
                sr_d = ref_q;
            end else if (tap.shift) begin
                sr_d = {tap.tdi, sr_q[31:1]};
            end else if (tap.update) begin
                ref_d = sr_q;
            end
        end
        tdo_d = sr_d[0];

        // Open-drain releases the pin to show an error
        pin_o_d  = od_mode ? 1'b0 : flag_d;
        pin_oe_d = od_mode ? ~flag_d : 1'b1;

        // Status outputs registered so the pins never see decode glitches
        user_d = (state_d == CMC_S_USER);
        cerr_d = (state_d == CMC_S_CFG_ERR);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= CMC_S_CONFIG;
            wr_ptr_q      <= '0;
            word_cnt_q    <= '0;
            frame_cnt_q   <= '0;
            expect_fcrc_q <= 1'b0;
            frames_done_q <= 1'b0;
            fcrc_q        <= CMC_CRC16_INIT;
            ref_q         <= CMC_REF_RESET;
            crc_q         <= CMC_CRC32_INIT;
            rd_ptr_q      <= '0;
            sig_q         <= 32'h0000_0000;
            flag_q        <= 1'b0;
            sr_q          <= CMC_SR_RESET;
            tdo_q         <= 1'b0;
            pin_o_q       <= 1'b0;
            pin_oe_q      <= 1'b1;
            user_q        <= 1'b0;
            cerr_q        <= 1'b0;
        end else begin
            state_q       <= state_d;
            wr_ptr_q      <= wr_ptr_d;
            word_cnt_q    <= word_cnt_d;
            frame_cnt_q   <= frame_cnt_d;
            expect_fcrc_q <= expect_fcrc_d;
            frames_done_q <= frames_done_d;
            fcrc_q        <= fcrc_d;
            ref_q         <= ref_d;
            crc_q         <= crc_d;
            rd_ptr_q      <= rd_ptr_d;
            sig_q         <= sig_d;
            flag_q        <= flag_d;
            sr_q          <= sr_d;
            tdo_q         <= tdo_d;
            pin_o_q       <= pin_o_d;
            pin_oe_q      <= pin_oe_d;
            user_q        <= user_d;
            cerr_q        <= cerr_d;
        end
    end

    assign tdo               = tdo_q;
    assign user_mode         = user_q;
    assign cfg_error         = cerr_q;
    assign crc_mismatch_flag = flag_q;
    assign crc_pin_o         = pin_o_q;
    assign crc_pin_oe        = pin_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_bad_frame;
        fcrc_bad ##1 (state_q == CMC_S_CFG_ERR);
    endsequence

    a_frame_mismatch: assert property (
        fcrc_bad |-> s_bad_frame ##1 (state_q == CMC_S_CFG_ERR)[*2])
        else $error("frame CRC mismatch did not stop loading");

    a_ref_load: assert property (
        ref_take |=> ref_q == $past(cfg_in.data) && user_mode)
        else $error("reference not stored at end of loading");

    a_scan_moves: assert property (
        user_mode && check_enable |=> rd_ptr_q != $past(rd_ptr_q))
        else $error("scrubber stalled in user mode");

    a_flag_hold: assert property (
        !pass_end |=> $stable(crc_mismatch_flag))
        else $error("mismatch flag moved between pass ends");

    a_flag_set: assert property (
        pass_end && sig_d != 32'h0000_0000 |=> crc_mismatch_flag)
        else $error("non-zero signature left flag low");

    a_flag_clear: assert property (
        pass_end && sig_d == 32'h0000_0000 |=> !crc_mismatch_flag)
        else $error("zero signature left flag high");

    a_instr_gate: assert property (
        !user_mode && tap.update |=> $stable(ref_q) || user_mode)
        else $error("reference changed outside user mode");

    a_ref_update: assert property (
        tap_sel && tap.update && !tap.capture && !tap.shift
            |=> ref_q == $past(sr_q))
        else $error("update did not apply shifted value");

    a_shift_out: assert property (
        tap_sel && tap.shift && !tap.capture
            |=> tdo == $past(sr_q[1]) && sr_q[31] == $past(tap.tdi))
        else $error("shift path wrong");

    a_pin_mode: assert property (
        ##1 (crc_pin_oe == ($past(od_mode) ? !crc_mismatch_flag : 1'b1)))
        else $error("error pin drive mode wrong");

endmodule

// ---- verilog/cmc_pkg.sv ----
// Shared constants, types and CRC helpers of the configuration CRC checker
package cmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Constants
    localparam logic [31:0] CMC_CRC32_POLY = 32'h04C1_1DB7;
    localparam logic [31:0] CMC_CRC32_INIT = 32'hFFFF_FFFF;
    localparam logic [15:0] CMC_CRC16_POLY = 16'h8005;
    localparam logic [15:0] CMC_CRC16_INIT = 16'h0000;
    localparam int unsigned CMC_IR_W       = 10;
    // Code 00 0001 0101
    localparam logic [9:0]  CMC_IR_REF_LOAD = 10'h015;
    localparam logic [31:0] CMC_REF_RESET   = 32'h0000_0000;
    localparam logic [31:0] CMC_SR_RESET    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        CMC_K_DATA = 2'b00,
        CMC_K_FCRC = 2'b01,
        CMC_K_REF  = 2'b10,
        CMC_K_IDLE = 2'b11
    } cmc_kind_t;

    typedef enum logic [1:0] {
        CMC_S_CONFIG  = 2'b00,
        CMC_S_CFG_ERR = 2'b01,
        CMC_S_USER    = 2'b10
    } cmc_state_t;

    typedef struct packed {
        logic        valid;
        cmc_kind_t   kind;
        logic [31:0] data;
    } cmc_cfg_word_t;

    typedef struct packed {
        logic [CMC_IR_W-1:0] ir;
        logic                capture;
        logic                shift;
        logic                update;
        logic                tdi;
    } cmc_tap_t;

    ////////////////////////////////////////////////////////////////////////
    // CRC over one 32-bit word, MSB first, no reflection
    function automatic logic [31:0] cmc_crc32(input logic [31:0] c,
                                              input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ ((r[31] ^ w[i]) ? CMC_CRC32_POLY : '0);
        end
        return r;
    endfunction

    function automatic logic [15:0] cmc_crc16(input logic [15:0] c,
                                              input logic [31:0] w);
        logic [15:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? CMC_CRC16_POLY : '0);
        end
        return r;
    endfunction

endpackage
